// >>> design/rcp_top.sv
// Rail control pin logic: enables, sleep, outputs, programming entry.
// Notes on behaviour
// - Open-drain interrupt pulls low while pending.
// - First three outputs select open-drain or push-pull.
// - Outputs follow power-good set or register bit.
// - Fourth output is always open-drain.
// - Enable inputs switch their rail group.
// - Input c low puts group asleep.
// - Sleeping rails use separate voltage settings.
// - Programming state needs stable high voltage.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module rcp_top (
  input  wire logic                       CLK,
  input  wire logic                       RESETN,
  input  wire logic [rcp_pkg::AW-1:0]     S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [rcp_pkg::DW-1:0]     S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  output logic [1:0]                      S_AXI_BRESP,
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  input  wire logic [rcp_pkg::AW-1:0]     S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  output logic [rcp_pkg::DW-1:0]          S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  input  wire logic                       RAIL_ENABLE_IN_B,
  input  wire logic                       RAIL_ENABLE_OR_SLEEP_IN_C,
  input  wire logic                       RAIL_ENABLE_OR_PROGRAM_IN_D,
  input  wire logic                       RAIL_ENABLE_IN_E,
  input  wire logic                       PROGRAM_HV_DETECT,
  input  wire logic [rcp_pkg::NR-1:0]     RAIL_POWER_GOOD,
  output logic [rcp_pkg::NR-1:0]          RAIL_ENABLE,
  output logic [rcp_pkg::NR-1:0]          RAIL_SLEEP,
  output logic [rcp_pkg::NR*rcp_pkg::VW-1:0] RAIL_VOUT_CODE,
  output logic                            PROGRAM_STATE,
  output logic                            GEN_OUT_A_O,
  output logic                            GEN_OUT_A_OE_N,
  output logic                            GEN_OUT_B_O,
  output logic                            GEN_OUT_B_OE_N,
  output logic                            GEN_OUT_C_O,
  output logic                            GEN_OUT_C_OE_N,
  output logic                            GEN_OUT_D_O,
  output logic                            GEN_OUT_D_OE_N,
  output logic                            INTERRUPT_OUT_N_O,
  output logic                            INTERRUPT_OUT_N_OE_N
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [rcp_pkg::AW-1:0] reg_at(
    input logic [rcp_pkg::AW-1:0] base, input int i);
    return base + 8'(i * 4);
  endfunction : reg_at

  function automatic logic [rcp_pkg::DW-1:0] merge(
    input logic [rcp_pkg::DW-1:0] old, input logic [rcp_pkg::DW-1:0] nw,
    input logic [3:0] strb);
    logic [rcp_pkg::DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic known(input logic [rcp_pkg::AW-1:0] a);
    return a <= rcp_pkg::A_IRQ_MSK || a[7:5] == rcp_pkg::BANK_NORM ||
           a[7:5] == rcp_pkg::BANK_SLP;
  endfunction : known

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [rcp_pkg::NR+rcp_pkg::NIN:0] sync_q;
  logic [rcp_pkg::NR-1:0]            pg_s;
  logic                              in_b;
  logic                              in_c;
  logic                              in_d;
  logic                              in_e;
  logic                              hv_s;

  rcp_sync #(.W(rcp_pkg::NR + rcp_pkg::NIN + 1)) u_sync (
    .clk   (CLK),
    .rst_n (RESETN),
    .d     ({RAIL_POWER_GOOD, PROGRAM_HV_DETECT, RAIL_ENABLE_IN_E,
             RAIL_ENABLE_OR_PROGRAM_IN_D, RAIL_ENABLE_OR_SLEEP_IN_C,
             RAIL_ENABLE_IN_B}),
    .q     (sync_q)
  );
  assign {pg_s, hv_s, in_e, in_d, in_c, in_b} = sync_q;

  // ****************************************************************
  // Configuration registers and bus slave
  // ****************************************************************
  logic [rcp_pkg::NR-1:0] grp_b, grp_c, grp_d, grp_e, slp_grp;
  logic [rcp_pkg::NR-1:0] pg_sel [rcp_pkg::NG];
  logic [rcp_pkg::VW-1:0] vnorm [rcp_pkg::NR];
  logic [rcp_pkg::VW-1:0] vslp [rcp_pkg::NR];
  logic [rcp_pkg::DW-1:0] ctrl, go_cfg;
  logic [rcp_pkg::IRQ_W-1:0] irq_st, irq_msk, irq_ev;
  logic [rcp_pkg::AW-1:0] wa;
  logic [rcp_pkg::DW-1:0] wd;
  logic [3:0]             ws;
  logic                   aw_got, w_got, wr_en, prog_on, slp_mode;
  logic [rcp_pkg::DW-1:0] rd;

  assign wr_en    = aw_got & w_got & !S_AXI_BVALID;
  assign slp_mode = ctrl[rcp_pkg::CTRL_SLEEP_C];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      wa     <= '0;
      wd     <= '0;
      ws     <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= rcp_pkg::RESP_OK;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got        <= 1'b1;
        wa            <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got        <= 1'b1;
        wd           <= S_AXI_WDATA;
        ws           <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_en) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= known(wa) ? rcp_pkg::RESP_OK : rcp_pkg::RESP_ERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl    <= '0;
      go_cfg  <= '0;
      grp_b   <= rcp_pkg::RST_GRP;
      grp_c   <= rcp_pkg::RST_GRP;
      grp_d   <= rcp_pkg::RST_GRP;
      grp_e   <= rcp_pkg::RST_GRP;
      slp_grp <= rcp_pkg::RST_GRP;
      irq_msk <= '0;
      for (int i = 0; i < rcp_pkg::NG; i++) pg_sel[i] <= rcp_pkg::RST_GRP;
      for (int i = 0; i < rcp_pkg::NR; i++) begin
        vnorm[i] <= rcp_pkg::RST_VSET;
        vslp[i]  <= rcp_pkg::RST_VSET;
      end
    end else if (wr_en) begin
      unique case (wa)
        rcp_pkg::A_CTRL:    ctrl    <= merge(ctrl, wd, ws);
        rcp_pkg::A_GO_CFG:  go_cfg  <= merge(go_cfg, wd, ws);
        rcp_pkg::A_GRP_B:   grp_b   <= ws[0] ? wd[rcp_pkg::NR-1:0] : grp_b;
        rcp_pkg::A_GRP_C:   grp_c   <= ws[0] ? wd[rcp_pkg::NR-1:0] : grp_c;
        rcp_pkg::A_GRP_D:   grp_d   <= ws[0] ? wd[rcp_pkg::NR-1:0] : grp_d;
        rcp_pkg::A_GRP_E:   grp_e   <= ws[0] ? wd[rcp_pkg::NR-1:0] : grp_e;
        rcp_pkg::A_SLP_GRP: slp_grp <= ws[0] ? wd[rcp_pkg::NR-1:0] : slp_grp;
        rcp_pkg::A_IRQ_MSK: irq_msk <= ws[0] ? wd[rcp_pkg::IRQ_W-1:0]
                                             : irq_msk;
        default: begin
          for (int i = 0; i < rcp_pkg::NG; i++) begin
            if (wa == reg_at(rcp_pkg::A_PG_SEL, i) && ws[0]) begin
              pg_sel[i] <= wd[rcp_pkg::NR-1:0];
            end
          end
          for (int i = 0; i < rcp_pkg::NR; i++) begin
            if (wa == reg_at(rcp_pkg::A_VNORM, i) && ws[0]) begin
              vnorm[i] <= wd[rcp_pkg::VW-1:0];
            end
            if (wa == reg_at(rcp_pkg::A_VSLP, i) && ws[0]) begin
              vslp[i] <= wd[rcp_pkg::VW-1:0];
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    rd = '0;
    unique case (S_AXI_ARADDR)
      rcp_pkg::A_CTRL:    rd = ctrl;
      rcp_pkg::A_GO_CFG:  rd = go_cfg;
      rcp_pkg::A_GRP_B:   rd[rcp_pkg::NR-1:0] = grp_b;
      rcp_pkg::A_GRP_C:   rd[rcp_pkg::NR-1:0] = grp_c;
      rcp_pkg::A_GRP_D:   rd[rcp_pkg::NR-1:0] = grp_d;
      rcp_pkg::A_GRP_E:   rd[rcp_pkg::NR-1:0] = grp_e;
      rcp_pkg::A_SLP_GRP: rd[rcp_pkg::NR-1:0] = slp_grp;
      rcp_pkg::A_IRQ_ST:  rd[rcp_pkg::IRQ_W-1:0] = irq_st;
      rcp_pkg::A_IRQ_MSK: rd[rcp_pkg::IRQ_W-1:0] = irq_msk;
      rcp_pkg::A_STATUS: begin
        rd[rcp_pkg::NR-1:0] = pg_s;
        rd[rcp_pkg::ST_PROG] = prog_on;
        rd[rcp_pkg::ST_IN_LSB +: rcp_pkg::NIN] = {in_e, in_d, in_c, in_b};
      end
      default: begin
        for (int i = 0; i < rcp_pkg::NG; i++) begin
          if (S_AXI_ARADDR == reg_at(rcp_pkg::A_PG_SEL, i)) begin
            rd[rcp_pkg::NR-1:0] = pg_sel[i];
          end
        end
        for (int i = 0; i < rcp_pkg::NR; i++) begin
          if (S_AXI_ARADDR == reg_at(rcp_pkg::A_VNORM, i)) begin
            rd[rcp_pkg::VW-1:0] = vnorm[i];
          end
          if (S_AXI_ARADDR == reg_at(rcp_pkg::A_VSLP, i)) begin
            rd[rcp_pkg::VW-1:0] = vslp[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= rcp_pkg::RESP_OK;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd;
      S_AXI_RRESP   <= known(S_AXI_ARADDR) ? rcp_pkg::RESP_OK
                                           : rcp_pkg::RESP_ERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************************************
  // Programming entry
  // ****************************************************************
  rcp_pkg::rcp_prog_t      prog_st;
  logic [rcp_pkg::PROG_CW-1:0] prog_cnt;

  // A glitch on the detector restarts qualification from zero.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prog_st  <= rcp_pkg::PS_IDLE;
      prog_cnt <= '0;
      prog_on  <= 1'b0;
    end else if (!hv_s) begin
      prog_st  <= rcp_pkg::PS_IDLE;
      prog_cnt <= '0;
      prog_on  <= 1'b0;
    end else begin
      unique case (prog_st)
        rcp_pkg::PS_IDLE: prog_st <= rcp_pkg::PS_QUAL;
        rcp_pkg::PS_QUAL: begin
          prog_cnt <= prog_cnt + 11'h001;
          if (prog_cnt == 11'(rcp_pkg::PROG_CYC - 1)) begin
            prog_st <= rcp_pkg::PS_ON;
            prog_on <= 1'b1;
          end
        end
        rcp_pkg::PS_ON: prog_on <= 1'b1;
      endcase
    end
  end
  assign PROGRAM_STATE = prog_on;

  // ****************************************************************
  // Rail enables, sleep and voltage codes
  // ****************************************************************
  logic [rcp_pkg::NR-1:0] slp_now;
  logic                   d_ok;

  // Input d is ignored while high voltage is seen so rails stay off.
  assign d_ok    = in_d & !hv_s;
  assign slp_now = {rcp_pkg::NR{slp_mode & !in_c}} & slp_grp;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RAIL_ENABLE <= '0;
      RAIL_SLEEP  <= '0;
    end else begin
      RAIL_ENABLE <= (grp_b & {rcp_pkg::NR{in_b}}) |
                     (grp_c & {rcp_pkg::NR{in_c & !slp_mode}}) |
                     (grp_d & {rcp_pkg::NR{d_ok}}) |
                     (grp_e & {rcp_pkg::NR{in_e}});
      RAIL_SLEEP  <= slp_now;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RAIL_VOUT_CODE <= '0;
    end else begin
      for (int i = 0; i < rcp_pkg::NR; i++) begin
        RAIL_VOUT_CODE[i*rcp_pkg::VW +: rcp_pkg::VW] <=
          slp_now[i] ? vslp[i] : vnorm[i];
      end
    end
  end

  // ****************************************************************
  // General-purpose outputs
  // ****************************************************************
  logic [rcp_pkg::NG-1:0] go_o, go_oe_n;

  for (genvar g = 0; g < rcp_pkg::NG; g++) begin : g_go
    rcp_gen_out #(.OD_ONLY(g == rcp_pkg::NG - 1)) u_go (
      .clk       (CLK),
      .rst_n     (RESETN),
      .pg        (pg_s),
      .pg_sel    (pg_sel[g]),
      .use_bit   (go_cfg[rcp_pkg::GO_SRC_LSB + g]),
      .bit_val   (go_cfg[rcp_pkg::GO_BIT_LSB + g]),
      .push_pull (go_cfg[rcp_pkg::GO_PP_LSB + g]),
      .out_o     (go_o[g]),
      .out_oe_n  (go_oe_n[g])
    );
  end
  assign {GEN_OUT_D_O, GEN_OUT_C_O, GEN_OUT_B_O, GEN_OUT_A_O} = go_o;
  assign {GEN_OUT_D_OE_N, GEN_OUT_C_OE_N, GEN_OUT_B_OE_N,
          GEN_OUT_A_OE_N} = go_oe_n;

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [rcp_pkg::NR-1:0] pg_q;
  logic                   slp_q, prog_q;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pg_q   <= '0;
      slp_q  <= 1'b0;
      prog_q <= 1'b0;
    end else begin
      pg_q   <= pg_s;
      slp_q  <= slp_mode & !in_c;
      prog_q <= prog_on;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[rcp_pkg::IRQ_PG_LOST] = |(pg_q & ~pg_s & RAIL_ENABLE);
    irq_ev[rcp_pkg::IRQ_PROG]    = prog_on & !prog_q;
    irq_ev[rcp_pkg::IRQ_SLP_IN]  = slp_mode & !in_c & !slp_q;
    irq_ev[rcp_pkg::IRQ_SLP_OUT] = slp_q & !(slp_mode & !in_c);
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_st <= '0;
    end else if (wr_en && wa == rcp_pkg::A_IRQ_ST && ws[0]) begin
      irq_st <= (irq_st & ~wd[rcp_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_st <= irq_st | irq_ev;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      INTERRUPT_OUT_N_O    <= 1'b0;
      INTERRUPT_OUT_N_OE_N <= 1'b1;
    end else begin
      INTERRUPT_OUT_N_O    <= 1'b0;
      INTERRUPT_OUT_N_OE_N <= !(|(irq_st & irq_msk));
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_irq_pull;
    (|(irq_st & irq_msk)) |=> !INTERRUPT_OUT_N_OE_N && !INTERRUPT_OUT_N_O;
  endproperty
  a_irq_pull: assert property (p_irq_pull) else $error("irq not pulled");
  property p_irq_rel;
    !(|(irq_st & irq_msk)) |=> INTERRUPT_OUT_N_OE_N;
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq not freed");
  property p_en_on;
    in_b |=> (RAIL_ENABLE & $past(grp_b)) == $past(grp_b);
  endproperty
  a_en_on: assert property (p_en_on) else $error("group b not on");
  property p_en_off;
    (!in_b && !in_c && !in_d && !in_e) |=> RAIL_ENABLE == '0;
  endproperty
  a_en_off: assert property (p_en_off) else $error("rails not off");
  property p_slp;
    (slp_mode && !in_c) |=> RAIL_SLEEP == $past(slp_grp);
  endproperty
  a_slp: assert property (p_slp) else $error("sleep not entered");
  property p_wake;
    (slp_mode && in_c) |=> RAIL_SLEEP == '0;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep not left");
  property p_vsel;
    slp_now[0] |=> RAIL_VOUT_CODE[rcp_pkg::VW-1:0] == $past(vslp[0]);
  endproperty
  a_vsel: assert property (p_vsel) else $error("sleep code wrong");
  sequence s_quiet;
    !prog_on [*8];
  endsequence
  property p_prog_wait;
    $rose(hv_s) |=> s_quiet;
  endproperty
  a_prog_wait: assert property (p_prog_wait) else $error("early prog");
  property p_prog_hold;
    prog_on |-> $past(hv_s);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("prog w/o hv");
endmodule : rcp_top

// >>> design/rcp_pkg.sv
// Shared constants for the rail control pin logic.
package rcp_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NR    = 8;
  localparam int NG    = 4;
  localparam int VW    = 8;
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int NIN   = 4;
  localparam int IRQ_W = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [AW-1:0] A_CTRL    = 8'h00;
  localparam logic [AW-1:0] A_GRP_B   = 8'h04;
  localparam logic [AW-1:0] A_GRP_C   = 8'h08;
  localparam logic [AW-1:0] A_GRP_D   = 8'h0c;
  localparam logic [AW-1:0] A_GRP_E   = 8'h10;
  localparam logic [AW-1:0] A_SLP_GRP = 8'h14;
  localparam logic [AW-1:0] A_GO_CFG  = 8'h18;
  localparam logic [AW-1:0] A_PG_SEL  = 8'h1c;
  localparam logic [AW-1:0] A_STATUS  = 8'h2c;
  localparam logic [AW-1:0] A_IRQ_ST  = 8'h30;
  localparam logic [AW-1:0] A_IRQ_MSK = 8'h34;
  localparam logic [AW-1:0] A_VNORM   = 8'h40;
  localparam logic [AW-1:0] A_VSLP    = 8'h60;
  localparam logic [AW-1:0] A_STEP    = 8'h04;
  localparam logic [2:0]    BANK_NORM = 3'h2;
  localparam logic [2:0]    BANK_SLP  = 3'h3;

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int CTRL_SLEEP_C = 0;
  localparam int GO_SRC_LSB   = 0;
  localparam int GO_PP_LSB    = 4;
  localparam int GO_BIT_LSB   = 8;
  localparam int ST_PROG      = 8;
  localparam int ST_IN_LSB    = 9;
  localparam int IRQ_PG_LOST  = 0;
  localparam int IRQ_PROG     = 1;
  localparam int IRQ_SLP_IN   = 2;
  localparam int IRQ_SLP_OUT  = 3;

  localparam logic [NR-1:0] RST_GRP  = 8'h00;
  localparam logic [VW-1:0] RST_VSET = 8'h00;
  localparam logic [1:0]    RESP_OK  = 2'h0;
  localparam logic [1:0]    RESP_ERR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 125;
  localparam int PROG_STABLE_NS = 10000;
  localparam int PROG_CYC = (PROG_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CW  = 11;

  typedef enum logic [1:0] {PS_IDLE, PS_QUAL, PS_ON} rcp_prog_t;
endpackage : rcp_pkg

// >>> design/rcp_sync.sv
// Two flip-flop synchroniser for pin levels.
`timescale 1ns/1ns
module rcp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rcp_sync

// >>> design/rcp_gen_out.sv
// One general-purpose output with source select and output stage.
`timescale 1ns/1ns
module rcp_gen_out #(
  parameter bit OD_ONLY = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [rcp_pkg::NR-1:0] pg,
  input  wire logic [rcp_pkg::NR-1:0] pg_sel,
  input  wire logic                 use_bit,
  input  wire logic                 bit_val,
  input  wire logic                 push_pull,
  output logic                      out_o,
  output logic                      out_oe_n
);
  logic level;
  logic pp;

  // Empty selection reads as good, so an unused output idles high.
  assign level = use_bit ? bit_val : &(pg | ~pg_sel);
  assign pp    = push_pull & !OD_ONLY;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_o    <= 1'b0;
      out_oe_n <= 1'b1;
    end else if (pp) begin
      out_o    <= level;
      out_oe_n <= 1'b0;
    end else begin
      out_o    <= 1'b0;
      out_oe_n <= level;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_go_pp;
    pp |=> !out_oe_n && out_o == $past(level);
  endproperty
  a_go_pp: assert property (p_go_pp) else $error("push-pull level");
  property p_go_bit;
    (use_bit && !pp) |=> out_oe_n == $past(bit_val);
  endproperty
  a_go_bit: assert property (p_go_bit) else $error("bit source");
  property p_go_od;
    OD_ONLY |-> out_o == 1'b0;
  endproperty
  a_go_od: assert property (p_go_od) else $error("od only drove");
  property p_go_pg;
    (!use_bit && !pp && (pg & pg_sel) != pg_sel) |=> !out_oe_n;
  endproperty
  a_go_pg: assert property (p_go_pg) else $error("pg not all");
endmodule : rcp_gen_out

// >>> test/rcp_host_model.sv
// Host-side model that drives the control pins and rail good levels.
`timescale 1ns/1ns
module rcp_host_model (
  input  wire logic                   clk,
  output logic                        en_b,
  output logic                        en_c,
  output logic                        en_d,
  output logic                        en_e,
  output logic                        hv,
  output logic [rcp_pkg::NR-1:0]      pg
);
  // Input d rises only together with the high-voltage level.
  // The interrupt pin is never driven from here.
  initial begin
    {en_b, en_c, en_d, en_e, hv} = 5'h08;
    pg = 8'h00;
  end
  task automatic drive(input logic [4:0] v, input logic [7:0] g);
    @(posedge clk);
    {en_b, en_c, en_d, en_e, hv} <= v;
    pg <= g;
  endtask : drive
endmodule : rcp_host_model

// >>> test/test_rcp_top.sv
// Self-checking bench for the rail control pin logic.
`timescale 1ns/1ns
module test_rcp_top;
  logic CLK = 1'b0, RESETN = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdat;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, PROGRAM_STATE;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, RAIL_ENABLE_IN_B, RAIL_ENABLE_OR_SLEEP_IN_C;
  logic RAIL_ENABLE_IN_E, RAIL_ENABLE_OR_PROGRAM_IN_D, PROGRAM_HV_DETECT;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, br, rres;
  logic [7:0] RAIL_POWER_GOOD, RAIL_ENABLE, RAIL_SLEEP, mb, me, ms, sel, g;
  logic [63:0] RAIL_VOUT_CODE;
  logic GEN_OUT_A_O, GEN_OUT_A_OE_N, GEN_OUT_B_O, GEN_OUT_B_OE_N;
  logic GEN_OUT_C_O, GEN_OUT_C_OE_N, GEN_OUT_D_O, GEN_OUT_D_OE_N;
  logic INTERRUPT_OUT_N_O, INTERRUPT_OUT_N_OE_N;
  int err_total = 0, cmp_count = 0, cyc = 0;
  rcp_top uut (.*);
  rcp_host_model host (.clk(CLK), .en_b(RAIL_ENABLE_IN_B),
    .en_c(RAIL_ENABLE_OR_SLEEP_IN_C), .en_d(RAIL_ENABLE_OR_PROGRAM_IN_D),
    .en_e(RAIL_ENABLE_IN_E), .hv(PROGRAM_HV_DETECT), .pg(RAIL_POWER_GOOD));
  initial forever #4 CLK = ~CLK;
  // ****************
  // Bench tasks
  // ****************
  task automatic chk(input string n, input logic [63:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // The slave may take address and data at different edges.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    br = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    rdat = S_AXI_RDATA;
    rres = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(80108));
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    chk("irq", INTERRUPT_OUT_N_OE_N, 1'b1);
    mb = 8'($urandom);
    me = 8'($urandom);
    ms = 8'($urandom) | 8'h01;
    sel = 8'($urandom) | 8'h02;
    wr(rcp_pkg::A_GRP_B, {24'h0, mb});
    wr(rcp_pkg::A_GRP_E, {24'h0, me});
    for (int i = 0; i < 4; i++) begin
      host.drive({i[1], 2'b10, i[0], 1'b0}, 8'h00);
      repeat (5) @(posedge CLK);
      chk("enable", RAIL_ENABLE, (i[1] ? mb : 8'h0) | (i[0] ? me : 8'h0));
    end
    wr(rcp_pkg::A_CTRL, 32'h1);
    wr(rcp_pkg::A_SLP_GRP, {24'h0, ms});
    wr(rcp_pkg::A_VNORM, 32'h22);
    wr(rcp_pkg::A_VSLP, 32'h5a);
    wr(rcp_pkg::A_IRQ_MSK, 32'h4);
    for (int i = 0; i < 2; i++) begin
      host.drive({1'b0, i[0], 3'b000}, 8'h00);
      repeat (5) @(posedge CLK);
      chk("sleep", RAIL_SLEEP, i[0] ? 8'h00 : ms);
      chk("vout", RAIL_VOUT_CODE[7:0], i[0] ? 8'h22 : 8'h5a);
      chk("irq", INTERRUPT_OUT_N_OE_N, 1'b0);
    end
    wr(rcp_pkg::A_IRQ_ST, 32'h4);
    repeat (2) @(posedge CLK);
    chk("irq", INTERRUPT_OUT_N_OE_N, 1'b1);
    wr(rcp_pkg::A_PG_SEL, {24'h0, sel});
    for (int i = 0; i < 6; i++) begin
      wr(rcp_pkg::A_GO_CFG, i[1] ? 32'h888 : 32'h98);
      g = 8'($urandom) | (i[0] ? sel : 8'h00);
      host.drive(5'h08, g);
      repeat (5) @(posedge CLK);
      chk("a", GEN_OUT_A_O, i[1] ? 1'b0 : (g & sel) == sel);
      chk("a oe", GEN_OUT_A_OE_N, i[1] ? (g & sel) == sel : 1'b0);
      chk("d", GEN_OUT_D_O, 1'b0);
      chk("d oe", GEN_OUT_D_OE_N, i[1]);
      chk("b c", {GEN_OUT_B_O, GEN_OUT_B_OE_N, GEN_OUT_C_O, GEN_OUT_C_OE_N},
          4'b0101);
    end
    rd(8'h38);
    chk("rresp", rres, rcp_pkg::RESP_ERR);
    chk("rdata", rdat, 32'h0);
    wr(8'h3c, 32'h1);
    chk("bresp", br, rcp_pkg::RESP_ERR);
    host.drive(5'h0d, 8'hff);
    repeat (1000) @(posedge CLK);
    chk("prog", PROGRAM_STATE, 1'b0);
    repeat (300) @(posedge CLK);
    chk("prog", PROGRAM_STATE, 1'b1);
    host.drive(5'h08, 8'hff);
    repeat (5) @(posedge CLK);
    chk("prog", PROGRAM_STATE, 1'b0);
    complete_run();
  end
endmodule : test_rcp_top
